//--- rtl/duplex_regs_cfg.svh
`ifndef DUPLEX_REGS_CFG_SVH
`define DUPLEX_REGS_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define ADDR_THRESHOLD_GAIN   4'h4
`define ADDR_DIAG_CONTROL     4'h5

// ----------------------------------------
// Reset values and fixed low nibbles
// ----------------------------------------
`define THRESHOLD_GAIN_RESET  16'h0008
`define DIAG_CONTROL_RESET    16'h000a
`define LOW_NIBBLE_THRESHOLD  4'h8
`define LOW_NIBBLE_DIAG       4'ha

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_ACOUSTIC_DEPTH    14
`define POS_ACOUSTIC_FLOOR    12
`define POS_LINE_DEPTH        10
`define POS_LINE_FLOOR        8
`define POS_RECEIVE_BOOST     6
`define POS_TRANSMIT_BOOST    4
`define POS_INSTABILITY_OFF   15
`define POS_TONE_OFF          14
`define POS_ACOUSTIC_SHIFT    13
`define POS_LINE_SHIFT        12
`define POS_ACOUSTIC_FILTER   11
`define POS_LINE_FILTER       10
`define POS_ACOUSTIC_CANCEL   9
`define POS_LINE_CANCEL       8
`define POS_ACOUSTIC_INJECT   6
`define POS_LINE_INJECT       4

// ----------------------------------------
// Depth limits in dB for codes 00, 01, 10
// ----------------------------------------
`define DEPTH_CODE0_DB        6'd24
`define DEPTH_CODE1_DB        6'd18
`define DEPTH_CODE2_DB        6'd30

// ----------------------------------------
// Noise floors as positive dB below full scale
// ----------------------------------------
`define FLOOR_CODE1_DB        6'd42
`define FLOOR_CODE2_DB        6'd54

// ----------------------------------------
// Boost in half-dB steps
// ----------------------------------------
`define BOOST_CODE0_HDB       5'd0
`define BOOST_CODE1_HDB       5'd12
`define BOOST_CODE2_HDB       5'd19
`define BOOST_CODE3_HDB       5'd24

// ----------------------------------------
// Tone freeze length
// ----------------------------------------
`define TONE_FREEZE_NS        100000
`define TONE_FREEZE_CYCLES    ((`TONE_FREEZE_NS + 99) / 100)

`endif

//--- rtl/duplex_regs_pkg.sv
package duplex_regs_pkg;

  typedef struct packed {
    logic [1:0] acoustic_cancel_depth_limit;
    logic [1:0] acoustic_noise_floor_limit;
    logic [1:0] line_cancel_depth_limit;
    logic [1:0] line_noise_floor_limit;
    logic [1:0] receive_input_boost;
    logic [1:0] transmit_input_boost;
    logic [3:0] fixed;
  } threshold_gain_type;

  typedef struct packed {
    logic       instability_watch_off;
    logic       tone_watch_off;
    logic       acoustic_path_shift_watch_off;
    logic       line_path_shift_watch_off;
    logic       acoustic_emphasis_filter_off;
    logic       line_emphasis_filter_off;
    logic       acoustic_canceller_off;
    logic       line_canceller_off;
    logic [1:0] acoustic_coupling_inject_level;
    logic [1:0] line_coupling_inject_level;
    logic [3:0] fixed;
  } diag_control_type;

  // Per-canceller measurements from the signal path
  typedef struct packed {
    logic [5:0] cancel_depth_db;
    logic [5:0] noise_db_below_fs;
    logic       estimate_ok;
    logic       path_shift;
    logic       coupling_seen;
  } canceller_meas_type;

  // Per-canceller controls to the signal path
  typedef struct packed {
    logic       active;
    logic       clear_coeff;
    logic       freeze_adapt;
    logic       emphasis_on;
    logic [1:0] inject_level;
    logic       duplex_ok;
  } canceller_ctrl_type;

  typedef enum logic [1:0] {
    HALF_DUPLEX,
    FULL_DUPLEX
  } duplex_mode_type;

endpackage

//--- rtl/echo_duplex_control_regs.sv
`timescale 1ns/100ps
`include "duplex_regs_cfg.svh"
// Functional notes
// - Acoustic depth field 15-14: 00=24, 01=18, 10=30 dB, 11 reserved.
// - Acoustic noise floor field 13-12: 00=zero, 01=-42, 10=-54 dB.
// - Noise above acoustic floor uses depth limit, else asymptotic estimate.
// - Zero acoustic floor makes depth limit the only full-duplex criterion.
// - Line depth field 11-10 encodes like acoustic; full duplex needs excess.
// - Line noise floor field 9-8: 00=zero, 01=-42, 10=-54 dB.
// - Line floor selects depth limit or estimate; zero means depth only.
// - Nonzero line floor disables line canceller when no coupling seen.
// - Receive boost 7-6 and transmit boost 5-4: 0, 6, 9.5, 12 dB.
// - Bit 15 of diagnostic register stops instability clearing when set.
// - Instability event clears both cancellers and forces half duplex.
// - Tone in half duplex clears acoustic and forces receive; bit 14 disables.
// - Tone in full duplex briefly freezes acoustic adaptation.
// - Bits 13 and 12 disable acoustic and line path shift watches.
// - Bits 11 and 10 disable acoustic and line emphasis filters.
// - Bits 9 and 8 disable acoustic and line cancellers.
// - Disabled canceller leaves signal path and duplex decision.
// - Enabled path shift watch clears its canceller's coefficients.
// - Nonzero inject level adds a linear coupling path for training.
module echo_duplex_control_regs #(
  parameter int FREEZE_CYCLES = `TONE_FREEZE_CYCLES
) (
  // Clock and reset
  input  wire logic                                clk_sys_i,
  input  wire logic                                resetn_i,
  // Register port
  input  wire logic [3:0]                          reg_addr_i,
  input  wire logic [15:0]                         reg_wdata_i,
  input  wire logic                                reg_write_i,
  input  wire logic                                reg_read_i,
  output logic      [15:0]                         reg_rdata_o,
  // Signal path status
  input  wire duplex_regs_pkg::canceller_meas_type acoustic_meas_i,
  input  wire duplex_regs_pkg::canceller_meas_type line_meas_i,
  input  wire logic                                instability_i,
  input  wire logic                                tone_i,
  // Signal path control
  output duplex_regs_pkg::canceller_ctrl_type      acoustic_ctrl_o,
  output duplex_regs_pkg::canceller_ctrl_type      line_ctrl_o,
  output duplex_regs_pkg::duplex_mode_type         duplex_mode_o,
  output logic                                     force_receive_o,
  output logic      [4:0]                          receive_boost_hdb_o,
  output logic      [4:0]                          transmit_boost_hdb_o
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [5:0] depth_db(input logic [1:0] code);
    logic [5:0] r;
    r = `DEPTH_CODE0_DB;
    case (code)
      2'h1: r = `DEPTH_CODE1_DB;
      2'h2: r = `DEPTH_CODE2_DB;
      default: r = `DEPTH_CODE0_DB;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] floor_db(input logic [1:0] code);
    logic [5:0] r;
    r = 6'h00;
    case (code)
      2'h1: r = `FLOOR_CODE1_DB;
      2'h2: r = `FLOOR_CODE2_DB;
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  function automatic logic [4:0] boost_hdb(input logic [1:0] code);
    logic [4:0] r;
    r = `BOOST_CODE0_HDB;
    case (code)
      2'h1: r = `BOOST_CODE1_HDB;
      2'h2: r = `BOOST_CODE2_HDB;
      2'h3: r = `BOOST_CODE3_HDB;
      default: r = `BOOST_CODE0_HDB;
    endcase
    return r;
  endfunction

  // Gate for full duplex: noise above floor (smaller dB below FS) uses depth
  function automatic logic side_ok(input logic [1:0] depth_code,
                                   input logic [1:0] floor_code,
                                   input duplex_regs_pkg::canceller_meas_type m);
    logic use_depth;
    use_depth = (floor_code == 2'h0) ||
                (m.noise_db_below_fs < floor_db(floor_code));
    return use_depth ? (m.cancel_depth_db > depth_db(depth_code)) : m.estimate_ok;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  duplex_regs_pkg::threshold_gain_type threshold_gain;
  duplex_regs_pkg::diag_control_type   diag_control;
  duplex_regs_pkg::duplex_mode_type    mode;
  logic [15:0]                         rdata;
  logic [$clog2(FREEZE_CYCLES+1)-1:0]  freeze_count;

  wire write_thr  = reg_write_i && (reg_addr_i == `ADDR_THRESHOLD_GAIN);
  wire write_diag = reg_write_i && (reg_addr_i == `ADDR_DIAG_CONTROL);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      threshold_gain <= `THRESHOLD_GAIN_RESET;
      diag_control   <= `DIAG_CONTROL_RESET;
    end else begin
      if (write_thr) begin
        threshold_gain <= {reg_wdata_i[15:4], `LOW_NIBBLE_THRESHOLD};
      end
      if (write_diag) begin
        diag_control <= {reg_wdata_i[15:4], `LOW_NIBBLE_DIAG};
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [15:0] read_mux = (reg_addr_i == `ADDR_THRESHOLD_GAIN) ? threshold_gain :
                         (reg_addr_i == `ADDR_DIAG_CONTROL)   ? diag_control :
                         16'h0000;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= reg_read_i ? read_mux : 16'h0000;
    end
  end
  assign reg_rdata_o = rdata;

  // ----------------------------------------
  // Canceller enables and clears
  // ----------------------------------------
  wire acoustic_on = !diag_control.acoustic_canceller_off;
  wire line_auto_off = (threshold_gain.line_noise_floor_limit != 2'h0) &&
                       !line_meas_i.coupling_seen;
  wire line_on = !diag_control.line_canceller_off && !line_auto_off;

  wire howl_hit = instability_i && !diag_control.instability_watch_off;
  wire tone_hit = tone_i && !diag_control.tone_watch_off;
  wire tone_half = tone_hit && (mode == duplex_regs_pkg::HALF_DUPLEX);
  wire tone_full = tone_hit && (mode == duplex_regs_pkg::FULL_DUPLEX);

  wire acoustic_shift_clr = acoustic_meas_i.path_shift &&
                            !diag_control.acoustic_path_shift_watch_off;
  wire line_shift_clr = line_meas_i.path_shift &&
                        !diag_control.line_path_shift_watch_off;

  // Disabled cancellers do not vote
  wire acoustic_vote = !acoustic_on ||
    side_ok(threshold_gain.acoustic_cancel_depth_limit,
            threshold_gain.acoustic_noise_floor_limit, acoustic_meas_i);
  wire line_vote = !line_on ||
    side_ok(threshold_gain.line_cancel_depth_limit,
            threshold_gain.line_noise_floor_limit, line_meas_i);

  // ----------------------------------------
  // Duplex state and tone freeze
  // ----------------------------------------
  duplex_regs_pkg::duplex_mode_type next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      duplex_regs_pkg::HALF_DUPLEX: begin
        if (acoustic_vote && line_vote && !howl_hit && !tone_half) begin
          next_mode = duplex_regs_pkg::FULL_DUPLEX;
        end
      end
      duplex_regs_pkg::FULL_DUPLEX: begin
        if (howl_hit || !acoustic_vote || !line_vote) begin
          next_mode = duplex_regs_pkg::HALF_DUPLEX;
        end
      end
      default: next_mode = duplex_regs_pkg::HALF_DUPLEX;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode         <= duplex_regs_pkg::HALF_DUPLEX;
      freeze_count <= '0;
    end else begin
      mode <= next_mode;
      if (tone_full) begin
        freeze_count <= ($bits(freeze_count))'(FREEZE_CYCLES);
      end else if (freeze_count != '0) begin
        freeze_count <= freeze_count - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  duplex_regs_pkg::canceller_ctrl_type acoustic_ctrl;
  duplex_regs_pkg::canceller_ctrl_type line_ctrl;
  logic                                force_receive;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      acoustic_ctrl <= '0;
      line_ctrl     <= '0;
      force_receive <= 1'b0;
    end else begin
      acoustic_ctrl.active       <= acoustic_on;
      acoustic_ctrl.clear_coeff  <= howl_hit || tone_half || acoustic_shift_clr;
      acoustic_ctrl.freeze_adapt <= tone_full || (freeze_count > 1);
      acoustic_ctrl.emphasis_on  <= !diag_control.acoustic_emphasis_filter_off;
      acoustic_ctrl.inject_level <= diag_control.acoustic_coupling_inject_level;
      acoustic_ctrl.duplex_ok    <= acoustic_vote;
      line_ctrl.active           <= line_on;
      line_ctrl.clear_coeff      <= howl_hit || line_shift_clr;
      line_ctrl.freeze_adapt     <= 1'b0;
      line_ctrl.emphasis_on      <= !diag_control.line_emphasis_filter_off;
      line_ctrl.inject_level     <= diag_control.line_coupling_inject_level;
      line_ctrl.duplex_ok        <= line_vote;
      force_receive              <= tone_half;
    end
  end

  assign acoustic_ctrl_o      = acoustic_ctrl;
  assign line_ctrl_o          = line_ctrl;
  assign duplex_mode_o        = mode;
  assign force_receive_o      = force_receive;
  assign receive_boost_hdb_o  = boost_hdb(threshold_gain.receive_input_boost);
  assign transmit_boost_hdb_o = boost_hdb(threshold_gain.transmit_input_boost);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_howl_clears_both: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (instability_i && !diag_control.instability_watch_off) |=>
      (acoustic_ctrl.clear_coeff && line_ctrl.clear_coeff))
    else $error("instability did not clear both cancellers");

  a_howl_off_holds: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (instability_i && diag_control.instability_watch_off && !tone_i &&
     !acoustic_meas_i.path_shift && !line_meas_i.path_shift) |=>
      (!acoustic_ctrl.clear_coeff && !line_ctrl.clear_coeff))
    else $error("disabled instability watch still cleared");

  a_howl_half_duplex: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    howl_hit |=> (mode == duplex_regs_pkg::HALF_DUPLEX))
    else $error("instability did not force half duplex");

  sequence tone_in_half;
    tone_i && !diag_control.tone_watch_off && (mode == duplex_regs_pkg::HALF_DUPLEX);
  endsequence
  a_tone_receive: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    tone_in_half |=> (force_receive_o && acoustic_ctrl.clear_coeff))
    else $error("tone in half duplex not handled");

  sequence tone_in_full;
    tone_i && !diag_control.tone_watch_off && (mode == duplex_regs_pkg::FULL_DUPLEX);
  endsequence
  a_tone_freeze: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    tone_in_full |=> acoustic_ctrl.freeze_adapt)
    else $error("tone in full duplex did not freeze");

  a_write_threshold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (reg_write_i && reg_addr_i == `ADDR_THRESHOLD_GAIN) |=>
      (threshold_gain[15:4] == $past(reg_wdata_i[15:4])))
    else $error("threshold register write lost");

  a_read_diag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (reg_read_i && !reg_write_i && reg_addr_i == `ADDR_DIAG_CONTROL) |=>
      (reg_rdata_o == $past(diag_control)))
    else $error("diagnostic readback wrong");

  a_canceller_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    diag_control.acoustic_canceller_off |=> !acoustic_ctrl.active)
    else $error("disabled canceller still active");

  a_line_auto_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (threshold_gain.line_noise_floor_limit != 2'h0 && !line_meas_i.coupling_seen) |=>
      !line_ctrl.active)
    else $error("line canceller not auto disabled");

  a_boost_code: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (threshold_gain.receive_input_boost == 2'h2) |-> (receive_boost_hdb_o == 5'd19))
    else $error("receive boost decode wrong");

  a_line_off_inactive: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    diag_control.line_canceller_off |=> !line_ctrl.active)
    else $error("line canceller still active");

  a_off_votes_yes: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !acoustic_on |=> acoustic_ctrl.duplex_ok)
    else $error("disabled canceller voted");

  a_shift_clears_acoustic: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (acoustic_meas_i.path_shift && !diag_control.acoustic_path_shift_watch_off)
      |=> acoustic_ctrl.clear_coeff)
    else $error("acoustic shift not cleared");

  a_shift_clears_line: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (line_meas_i.path_shift && !diag_control.line_path_shift_watch_off)
      |=> line_ctrl.clear_coeff)
    else $error("line shift not cleared");

  a_no_stray_clear: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!howl_hit && !tone_half && !acoustic_shift_clr) |=> !acoustic_ctrl.clear_coeff)
    else $error("acoustic clear without cause");

  a_emphasis_off: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    diag_control.line_emphasis_filter_off |=> !line_ctrl.emphasis_on)
    else $error("line emphasis still on");

  a_inject_level: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    1'b1 |=> (acoustic_ctrl.inject_level == $past(diag_control.acoustic_coupling_inject_level)))
    else $error("acoustic inject level wrong");

  a_depth_only_gate: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (acoustic_on && threshold_gain[15:12] == 4'h0 &&
     acoustic_meas_i.cancel_depth_db <= `DEPTH_CODE0_DB) |=> !acoustic_ctrl.duplex_ok)
    else $error("depth limit not enforced");

  a_half_needs_votes: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (mode == duplex_regs_pkg::HALF_DUPLEX && !(acoustic_vote && line_vote))
      |=> (mode == duplex_regs_pkg::HALF_DUPLEX))
    else $error("full duplex without votes");

  a_tone_off_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (tone_i && diag_control.tone_watch_off) |=> !force_receive_o)
    else $error("disabled tone watch acted");

endmodule

//--- sim/echo_duplex_control_regs_bench.sv
`timescale 1ns/100ps
`include "duplex_regs_cfg.svh"
module echo_duplex_control_regs_bench;
  localparam int FREEZE = 4;
  logic                                clk_sys_i;
  logic                                resetn_i;
  logic                                reg_write_i;
  logic                                reg_read_i;
  logic                                instability_i;
  logic                                tone_i;
  logic                                force_receive_o;
  logic [3:0]                          reg_addr_i;
  logic [15:0]                         reg_wdata_i;
  logic [15:0]                         reg_rdata_o;
  logic [4:0]                          receive_boost_hdb_o;
  logic [4:0]                          transmit_boost_hdb_o;
  duplex_regs_pkg::canceller_meas_type acoustic_meas_i;
  duplex_regs_pkg::canceller_meas_type line_meas_i;
  duplex_regs_pkg::canceller_ctrl_type acoustic_ctrl_o;
  duplex_regs_pkg::canceller_ctrl_type line_ctrl_o;
  duplex_regs_pkg::duplex_mode_type    duplex_mode_o;
  int                                  fails;
  int                                  n_compared;
  logic [4:0]                          hdb [4] = '{`BOOST_CODE0_HDB, `BOOST_CODE1_HDB,
                                                   `BOOST_CODE2_HDB, `BOOST_CODE3_HDB};
  int                                  lim [3] = '{`DEPTH_CODE0_DB, `DEPTH_CODE1_DB,
                                                   `DEPTH_CODE2_DB};

  echo_duplex_control_regs #(.FREEZE_CYCLES(FREEZE)) echo_duplex_control_regs_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .acoustic_meas_i(acoustic_meas_i),
    .line_meas_i(line_meas_i), .instability_i(instability_i), .tone_i(tone_i),
    .acoustic_ctrl_o(acoustic_ctrl_o), .line_ctrl_o(line_ctrl_o),
    .duplex_mode_o(duplex_mode_o), .force_receive_o(force_receive_o),
    .receive_boost_hdb_o(receive_boost_hdb_o), .transmit_boost_hdb_o(transmit_boost_hdb_o));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic duplex_regs_pkg::canceller_meas_type mk(input int d, input int n,
                                                             input logic e, input logic c);
    return duplex_regs_pkg::canceller_meas_type'({6'(d), 6'(n), e, 1'b0, c});
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e, "read data");
    @(posedge clk_sys_i);
    #1;
    chk(reg_rdata_o, 16'h0000, "read data idle");
  endtask

  task automatic meas(input duplex_regs_pkg::canceller_meas_type a,
                      input duplex_regs_pkg::canceller_meas_type l);
    @(posedge clk_sys_i);
    acoustic_meas_i <= a;
    line_meas_i     <= l;
    @(posedge clk_sys_i);
    #1;
  endtask

  // Event kinds: 0 instability, 1 tone, 2 path shift on both cancellers
  task automatic pulse(input int w);
    @(posedge clk_sys_i);
    case (w)
      0: instability_i <= 1'b1;
      1: tone_i <= 1'b1;
      default: begin
        acoustic_meas_i.path_shift <= 1'b1;
        line_meas_i.path_shift     <= 1'b1;
      end
    endcase
    @(posedge clk_sys_i);
    instability_i              <= 1'b0;
    tone_i                     <= 1'b0;
    acoustic_meas_i.path_shift <= 1'b0;
    line_meas_i.path_shift     <= 1'b0;
    #1;
  endtask

  task automatic go_full;
    meas(mk(40, 60, 1'b1, 1'b1), mk(40, 60, 1'b1, 1'b1));
    for (int i = 0; i < 10 && duplex_mode_o !== duplex_regs_pkg::FULL_DUPLEX; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (duplex_mode_o !== duplex_regs_pkg::FULL_DUPLEX) begin
      fails++;
      $display("MISMATCH %0t full duplex never reached", $time);
      stop_test();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(4'h4, `THRESHOLD_GAIN_RESET);
    rd(4'h5, `DIAG_CONTROL_RESET);
    rd(4'h3, 16'h0000);
    chk(16'(receive_boost_hdb_o), 16'h0000, "rx boost reset");
    chk(16'(duplex_mode_o), 16'(duplex_regs_pkg::HALF_DUPLEX), "mode reset");
    $display("test reset done");
  endtask

  task automatic t_fields;
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {8'h00, 2'(c), 2'(c), 4'h8});
      chk(16'(receive_boost_hdb_o), 16'(hdb[c]), "rx boost");
      chk(16'(transmit_boost_hdb_o), 16'(hdb[c]), "tx boost");
    end
    wr(4'h4, 16'haaf7);
    wr(4'h3, 16'h1234);
    rd(4'h4, 16'haaf8);
    rd(4'h3, 16'h0000);
    wr(4'h5, 16'hfff5);
    rd(4'h5, 16'hfffa);
    wr(4'h5, `DIAG_CONTROL_RESET);
    wr(4'h4, `THRESHOLD_GAIN_RESET);
    $display("test fields done");
  endtask

  task automatic t_diag;
    meas(mk(0, 60, 1'b0, 1'b1), mk(0, 60, 1'b0, 1'b1));
    wr(4'h5, 16'h0c0a);
    chk(16'(acoustic_ctrl_o.emphasis_on), 16'h0000, "a emphasis");
    chk(16'(line_ctrl_o.emphasis_on), 16'h0000, "l emphasis");
    wr(4'h5, 16'h030a);
    chk(16'(acoustic_ctrl_o.active), 16'h0000, "a active");
    chk(16'(line_ctrl_o.active), 16'h0000, "l active");
    chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0001, "a off vote");
    for (int c = 0; c < 4; c++) begin
      wr(4'h5, {8'h00, 2'(c), 2'(c), 4'ha});
      chk(16'(acoustic_ctrl_o.inject_level), 16'(c), "a inject");
      chk(16'(line_ctrl_o.inject_level), 16'(c), "l inject");
    end
    chk(16'(acoustic_ctrl_o.active), 16'h0001, "a active on");
    chk(16'(line_ctrl_o.emphasis_on), 16'h0001, "l emphasis on");
    wr(4'h5, `DIAG_CONTROL_RESET);
    $display("test diag done");
  endtask

  task automatic t_depth;
    for (int c = 0; c < 3; c++) begin
      wr(4'h4, {2'(c), 2'b00, 2'(c), 2'b00, 8'h08});
      meas(mk(lim[c], 60, 1'b0, 1'b1), mk(lim[c], 60, 1'b0, 1'b1));
      chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0000, "a depth equal");
      chk(16'(line_ctrl_o.duplex_ok), 16'h0000, "l depth equal");
      meas(mk(lim[c] + 1, 60, 1'b0, 1'b1), mk(lim[c] + 1, 60, 1'b0, 1'b1));
      chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0001, "a depth above");
      chk(16'(line_ctrl_o.duplex_ok), 16'h0001, "l depth above");
    end
    $display("test depth done");
  endtask

  task automatic t_floor;
    wr(4'h4, 16'h1208);
    meas(mk(20, 30, 1'b1, 1'b1), mk(20, 40, 1'b1, 1'b1));
    chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0000, "a noisy");
    chk(16'(line_ctrl_o.duplex_ok), 16'h0000, "l noisy");
    meas(mk(20, 50, 1'b1, 1'b1), mk(20, 60, 1'b1, 1'b1));
    chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0001, "a quiet");
    chk(16'(line_ctrl_o.duplex_ok), 16'h0001, "l quiet");
    chk(16'(line_ctrl_o.active), 16'h0001, "l coupled");
    meas(mk(20, 50, 1'b0, 1'b1), mk(20, 60, 1'b1, 1'b0));
    chk(16'(acoustic_ctrl_o.duplex_ok), 16'h0000, "a no estimate");
    chk(16'(line_ctrl_o.active), 16'h0000, "l no coupling");
    wr(4'h4, `THRESHOLD_GAIN_RESET);
    $display("test floor done");
  endtask

  task automatic t_instab;
    go_full();
    pulse(0);
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0001, "a howl clear");
    chk(16'(line_ctrl_o.clear_coeff), 16'h0001, "l howl clear");
    chk(16'(duplex_mode_o), 16'(duplex_regs_pkg::HALF_DUPLEX), "howl half");
    wr(4'h5, 16'h800a);
    go_full();
    pulse(0);
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0000, "a howl off");
    chk(16'(line_ctrl_o.clear_coeff), 16'h0000, "l howl off");
    wr(4'h5, `DIAG_CONTROL_RESET);
    $display("test instability done");
  endtask

  task automatic t_tone;
    int k;
    meas(mk(0, 60, 1'b0, 1'b1), mk(0, 60, 1'b0, 1'b1));
    pulse(1);
    chk(16'(force_receive_o), 16'h0001, "tone receive");
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0001, "tone clear");
    wr(4'h5, 16'h400a);
    pulse(1);
    chk(16'(force_receive_o), 16'h0000, "tone off receive");
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0000, "tone off clear");
    wr(4'h5, `DIAG_CONTROL_RESET);
    go_full();
    pulse(1);
    chk(16'(force_receive_o), 16'h0000, "tone full receive");
    chk(16'(line_ctrl_o.freeze_adapt), 16'h0000, "l no freeze");
    k = 0;
    for (int i = 0; i < 20; i++) begin
      if (acoustic_ctrl_o.freeze_adapt === 1'b1) k++;
      @(posedge clk_sys_i);
      #1;
    end
    chk(16'(k), 16'(FREEZE), "freeze length");
    $display("test tone done");
  endtask

  task automatic t_shift;
    meas(mk(0, 60, 1'b0, 1'b1), mk(0, 60, 1'b0, 1'b1));
    pulse(2);
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0001, "a shift clear");
    chk(16'(line_ctrl_o.clear_coeff), 16'h0001, "l shift clear");
    wr(4'h5, 16'h300a);
    pulse(2);
    chk(16'(acoustic_ctrl_o.clear_coeff), 16'h0000, "a shift off");
    chk(16'(line_ctrl_o.clear_coeff), 16'h0000, "l shift off");
    $display("test path shift done");
  endtask

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    fails = 0;
    n_compared = 0;
    resetn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    instability_i = 1'b0;
    tone_i = 1'b0;
    acoustic_meas_i = '0;
    line_meas_i = '0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset();
    t_fields();
    t_diag();
    t_depth();
    t_floor();
    t_instab();
    t_tone();
    t_shift();
    stop_test();
  end
endmodule
